// ### rtl/spi_event_detect.sv
// spi_event_detect: turns fifo levels, access strobes and select activity
// into per-flag set and hardware-clear requests, plus the clock stall.
// assumes: all inputs synchronous to pclk; select inputs active low.
`timescale 1ns/100ps
module spi_event_detect (
	input  wire logic pclk,    // system clock
	input  wire logic presetn, // async reset, active low
	spi_event_if.det  ev       // event link to the register block
);
	import spi_flags_pkg::*;

	logic sel_n_q_r;
	logic rx_full_q_r;
	logic done_q_r;
	logic rx_full;
	logic tx_empty;
	logic count_hit;

	// =====================================================================
	// history for edge detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_n_q_r   <= 1'b1;
			rx_full_q_r <= 1'b0;
			done_q_r    <= 1'b0;
		end else begin
			sel_n_q_r   <= ev.sel_n;
			rx_full_q_r <= rx_full;
			done_q_r    <= count_hit;
		end
	end

	assign rx_full   = (ev.rx_level == FIFO_DEPTH);
	assign tx_empty  = (ev.tx_level == LVL_EMPTY);
	assign count_hit = ev.controller && (ev.char_count == ev.num_char);

	// =====================================================================
	// set conditions
	always_comb begin
		ev.set_vec = '0;
		ev.set_vec[BIT_RX_UNDERRUN] = ev.rx_pop && (ev.rx_level == LVL_EMPTY);
		ev.set_vec[BIT_RX_OVERRUN]  = !ev.controller && ev.rx_push && rx_full;
		ev.set_vec[BIT_TX_UNDERRUN] = !ev.controller && ev.tx_pop && tx_empty;
		ev.set_vec[BIT_TX_OVERRUN]  = ev.tx_push && (ev.tx_level == FIFO_DEPTH);
		ev.set_vec[BIT_DONE]    = count_hit && !done_q_r;
		ev.set_vec[BIT_ABORT]   = !ev.controller && ev.sel_n && !sel_n_q_r && ev.char_partial;
		ev.set_vec[BIT_FAULT]   = (ev.controller && ev.multi_en && !ev.psel_in_n)
		                          || ev.collision;
		ev.set_vec[BIT_SS_DEA]  = ev.sel_n && !sel_n_q_r;
		ev.set_vec[BIT_SS_ASS]  = !ev.sel_n && sel_n_q_r;
		ev.set_vec[BIT_RX_FULL] = rx_full && !rx_full_q_r;
		ev.set_vec[BIT_RX_THD]  = ev.rx_level > {1'b0, ev.rx_thr};
		ev.set_vec[BIT_TX_EMPTY] = tx_empty;
		ev.set_vec[BIT_TX_THD]  = ev.tx_level < {1'b0, ev.tx_thr};
	end

	// =====================================================================
	// hardware clears of the level-tracking threshold flags
	always_comb begin
		ev.hw_clr = '0;
		ev.hw_clr[BIT_RX_THD] = ev.rx_level < {1'b0, ev.rx_thr};
		ev.hw_clr[BIT_TX_THD] = ev.tx_level > {1'b0, ev.tx_thr};
	end

	// controller holds its serial clock instead of over/underrunning
	assign ev.stall = ev.controller && (rx_full || tx_empty);

endmodule

// ### rtl/spi_event_flags.sv
// spi_event_flags: event flag register block of the serial unit, with an
// APB slave, interrupt enable mask, threshold and mode registers.
// assumes: fifo levels, strobes and select inputs come synchronous to pclk;
// fifo depth 32; selects active low.
//
// Overview of operation
// - reading an empty receive fifo sets the receive underrun flag, bit 15.
// - peripheral mode write into a full receive fifo sets receive overrun, bit 14.
// - controller mode stalls clock on full receive fifo; never sets receive overrun.
// - controller mode stalls clock on empty transmit fifo; no transmit underrun.
// - write into a full transmit fifo sets transmit overrun flag, bit 12.
// - controller mode sets done flag, bit 11, when character count is reached.
// - peripheral select released mid-character sets abort flag, bit 9.
// - controller with multi-controller enabled sets fault, bit 8, on active select input.
// - a bus collision also sets the fault flag, bit 8.
// - select release sets bit 5; select assertion sets bit 4.
// - receive fifo becoming full sets receive full flag, bit 3.
// - receive level above threshold sets bit 2; below threshold clears it.
// - empty transmit fifo sets transmit empty flag, bit 1; resets to one.
// - transmit level below threshold sets bit 0; above threshold clears it.
// - receive threshold is dma control bits 20:16; 0 to 30 valid, 31 invalid.
// - transmit threshold is dma control bits 4:0, reset value 0x10.
`timescale 1ns/100ps
module spi_event_flags (
	input  wire logic                              pclk,          // system clock, 20 MHz
	input  wire logic                              presetn,       // async reset, active low
	input  wire logic                              psel,          // apb select
	input  wire logic                              penable,       // apb access phase
	input  wire logic                              pwrite,        // apb direction, 1 = write
	input  wire logic [spi_flags_pkg::ADDR_W-1:0]  paddr,         // apb byte address
	input  wire logic [31:0]                       pwdata,        // apb write data
	output logic      [31:0]                       prdata,        // apb read data
	output logic                                   pready,        // apb ready
	output logic                                   pslverr,       // apb error on unmapped address
	input  wire logic [spi_flags_pkg::LVL_W-1:0]   rx_level,      // receive fifo fill level
	input  wire logic [spi_flags_pkg::LVL_W-1:0]   tx_level,      // transmit fifo fill level
	input  wire logic                              rx_pop,        // attempt to read receive fifo
	input  wire logic                              rx_push,       // shifter writes a received char
	input  wire logic                              tx_pop,        // shifter fetches a char to send
	input  wire logic                              tx_push,       // attempt to write transmit fifo
	input  wire logic [spi_flags_pkg::NUM_W-1:0]   char_count,    // characters sent this transfer
	input  wire logic                              sel_n,         // own select line, active low
	input  wire logic                              psel_in_n,     // peripheral select input, active low
	input  wire logic                              char_partial,  // character reception in progress
	input  wire logic                              collision,     // bus collision seen
	output logic                                   irq,           // level interrupt
	output logic                                   sclk_hold,     // controller must stall its clock
	output logic                                   controller,    // controller mode selected
	output logic [spi_flags_pkg::THR_W-1:0]        rx_thr,        // receive threshold setting
	output logic [spi_flags_pkg::THR_W-1:0]        tx_thr         // transmit threshold setting
);
	import spi_flags_pkg::*;

	spi_event_if ev ();

	logic [31:0] ctrl_r;
	logic [31:0] dma_r;
	flag_vec_t   flags_r;
	flag_vec_t   flags_nxt;
	flag_vec_t   inten_r;
	logic [31:0] prdata_r;
	logic        pready_r;
	logic        pslverr_r;
	logic        irq_r;
	logic        sclk_hold_r;
	logic [31:0] rd_mux;
	logic        mapped;
	logic        setup;
	logic        wr_en;
	flag_vec_t   sw_clr;

	// =====================================================================
	// apb decode
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite && pready_r && !pslverr_r;

	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h00000000;
		unique case (paddr)
			OFS_CTRL:  rd_mux = ctrl_r;
			OFS_DMA:   rd_mux = dma_r;
			OFS_FLAGS: rd_mux = {16'h0000, flags_r & FLAG_MASK};
			OFS_INTEN: rd_mux = {16'h0000, inten_r & FLAG_MASK};
			default:   mapped = 1'b0;
		endcase
	end

	// =====================================================================
	// apb response: ready one cycle after setup, so no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= setup;
			pslverr_r <= setup && !mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
		end else if (setup && !pwrite) begin
			prdata_r <= rd_mux;
		end else if (pready_r) begin
			prdata_r <= 32'h00000000;
		end
	end

	// =====================================================================
	// configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= CTRL_RST;
		end else if (wr_en && paddr == OFS_CTRL) begin
			ctrl_r <= pwdata & CTRL_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_r <= DMA_RST;
		end else if (wr_en && paddr == OFS_DMA) begin
			dma_r <= pwdata & DMA_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inten_r <= '0;
		end else if (wr_en && paddr == OFS_INTEN) begin
			inten_r <= pwdata[FLAG_W-1:0] & FLAG_MASK;
		end
	end

	// =====================================================================
	// detector link
	assign ev.controller   = ctrl_r[CTRL_MODE_BIT];
	assign ev.multi_en     = ctrl_r[CTRL_MULTI_BIT];
	assign ev.num_char     = ctrl_r[CTRL_NUM_LSB +: NUM_W];
	assign ev.rx_thr       = dma_r[DMA_RXT_LSB +: THR_W];
	assign ev.tx_thr       = dma_r[DMA_TXT_LSB +: THR_W];
	assign ev.char_count   = char_count;
	assign ev.rx_level     = rx_level;
	assign ev.tx_level     = tx_level;
	assign ev.rx_pop       = rx_pop;
	assign ev.rx_push      = rx_push;
	assign ev.tx_pop       = tx_pop;
	assign ev.tx_push      = tx_push;
	assign ev.sel_n        = sel_n;
	assign ev.psel_in_n    = psel_in_n;
	assign ev.char_partial = char_partial;
	assign ev.collision    = collision;

	spi_event_detect detect (
		.pclk    (pclk),
		.presetn (presetn),
		.ev      (ev)
	);

	// =====================================================================
	// flag bits: set wins over any clear; reserved bits stay zero
	assign sw_clr = (wr_en && paddr == OFS_FLAGS) ? pwdata[FLAG_W-1:0] : '0;

	for (genvar i = 0; i < FLAG_W; i++) begin : g_flag
		if (FLAG_MASK[i]) begin : g_impl
			assign flags_nxt[i] = ev.set_vec[i] ? 1'b1 :
			                      (ev.hw_clr[i] || sw_clr[i]) ? 1'b0 : flags_r[i];
		end else begin : g_rsvd
			assign flags_nxt[i] = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_r <= FLAG_RST;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// =====================================================================
	// interrupt and stall outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(flags_nxt & inten_r);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_hold_r <= 1'b0;
		end else begin
			sclk_hold_r <= ev.stall;
		end
	end

	assign prdata     = prdata_r;
	assign pready     = pready_r;
	assign pslverr    = pslverr_r;
	assign irq        = irq_r;
	assign sclk_hold  = sclk_hold_r;
	assign controller = ctrl_r[CTRL_MODE_BIT];
	assign rx_thr     = dma_r[DMA_RXT_LSB +: THR_W];
	assign tx_thr     = dma_r[DMA_TXT_LSB +: THR_W];

endmodule

// ### rtl/spi_event_if.sv
// spi_event_if: carries configuration and fifo/select status from the
// flag register block to the event detector, and set/clear vectors back.
// assumes: both ends run on pclk.
`timescale 1ns/100ps
interface spi_event_if;
	import spi_flags_pkg::*;
	logic                 controller;
	logic                 multi_en;
	logic [THR_W-1:0]     rx_thr;
	logic [THR_W-1:0]     tx_thr;
	logic [NUM_W-1:0]     num_char;
	logic [NUM_W-1:0]     char_count;
	logic [LVL_W-1:0]     rx_level;
	logic [LVL_W-1:0]     tx_level;
	logic                 rx_pop;
	logic                 rx_push;
	logic                 tx_pop;
	logic                 tx_push;
	logic                 sel_n;
	logic                 psel_in_n;
	logic                 char_partial;
	logic                 collision;
	flag_vec_t            set_vec;
	flag_vec_t            hw_clr;
	logic                 stall;

	modport regs (output controller, multi_en, rx_thr, tx_thr, num_char, char_count, rx_level, tx_level,
	              output rx_pop, rx_push, tx_pop, tx_push, sel_n, psel_in_n, char_partial, collision,
	              input set_vec, hw_clr, stall);
	modport det  (input controller, multi_en, rx_thr, tx_thr, num_char, char_count, rx_level, tx_level,
	              input rx_pop, rx_push, tx_pop, tx_push, sel_n, psel_in_n, char_partial, collision,
	              output set_vec, hw_clr, stall);
endinterface

// ### rtl/spi_flags_pkg.sv
// spi_flags_pkg: register map, field positions, reset values and flag bit
// numbers for the serial unit's event flag block.
// assumes: a 32-bit APB register bus and a 32-entry FIFO in each direction.
package spi_flags_pkg;

	// =====================================================================
	// register offsets
	localparam int          ADDR_W     = 12;
	localparam logic [11:0] OFS_CTRL   = 12'h000;
	localparam logic [11:0] OFS_DMA    = 12'h01C;
	localparam logic [11:0] OFS_FLAGS  = 12'h020;
	localparam logic [11:0] OFS_INTEN  = 12'h024;

	// =====================================================================
	// fifo geometry
	localparam int         LVL_W      = 6;
	localparam logic [5:0] FIFO_DEPTH = 6'h20;
	localparam logic [5:0] LVL_EMPTY  = 6'h00;

	// =====================================================================
	// control register fields
	localparam int CTRL_MODE_BIT  = 0;
	localparam int CTRL_MULTI_BIT = 1;
	localparam int CTRL_NUM_LSB   = 16;
	localparam int NUM_W          = 16;
	localparam logic [31:0] CTRL_MASK = 32'hFFFF0003;
	localparam logic [31:0] CTRL_RST  = 32'h00000000;

	// =====================================================================
	// dma control register fields
	localparam int          THR_W       = 5;
	localparam int          DMA_RXT_LSB = 16;
	localparam int          DMA_TXT_LSB = 0;
	localparam logic [31:0] DMA_MASK    = 32'h001F001F;
	localparam logic [31:0] DMA_RST     = 32'h00000010;

	// =====================================================================
	// event flag bits
	localparam int FLAG_W      = 16;
	localparam int BIT_RX_UNDERRUN = 15;
	localparam int BIT_RX_OVERRUN  = 14;
	localparam int BIT_TX_UNDERRUN = 13;
	localparam int BIT_TX_OVERRUN  = 12;
	localparam int BIT_DONE    = 11;
	localparam int BIT_ABORT   = 9;
	localparam int BIT_FAULT   = 8;
	localparam int BIT_SS_DEA  = 5;
	localparam int BIT_SS_ASS  = 4;
	localparam int BIT_RX_FULL = 3;
	localparam int BIT_RX_THD  = 2;
	localparam int BIT_TX_EMPTY = 1;
	localparam int BIT_TX_THD  = 0;
	localparam logic [15:0] FLAG_MASK = 16'hFB3F;
	localparam logic [15:0] FLAG_RST  = 16'h0002;

	typedef logic [FLAG_W-1:0] flag_vec_t;

endpackage

// ### verif/spi_event_flags_checker.sv
// spi_event_flags_checker: port-level assertions for the event flag block.
// assumes: bound to spi_event_flags; one clock domain, pclk.
`timescale 1ns/100ps
module spi_event_flags_checker import spi_flags_pkg::*; (
	input wire logic pclk, presetn, psel, penable, pwrite, pready, rx_pop, tx_push, collision,
	input wire logic sclk_hold, controller,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic [LVL_W-1:0] rx_level, tx_level,
	input wire logic [THR_W-1:0] tx_thr, rx_thr
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic rdf;
	// access edge of a flag read; it shows flags as of two edges back
	assign rdf = psel && penable && pready && !pwrite && paddr == OFS_FLAGS;
	chk_rsv_zero: assert property (rdf |-> prdata[31:16] == 16'h0000 && !prdata[10] && prdata[7:6] == 2'h0)
		else $error("reserved flag bits not zero");
	chk_rxun_set: assert property (rdf && $past(presetn, 2) && $past(rx_pop && rx_level == LVL_EMPTY, 2) |-> prdata[15])
		else $error("receive underrun not set");
	chk_txov_set: assert property (rdf && $past(presetn, 2) && $past(tx_push && tx_level == FIFO_DEPTH, 2) |-> prdata[12])
		else $error("transmit overrun not set");
	chk_txem_set: assert property (rdf && $past(presetn, 2) && $past(tx_level == LVL_EMPTY, 2) |-> prdata[1])
		else $error("transmit empty not set");
	chk_rxthd_set: assert property (rdf && $past(presetn, 2) && $past(rx_level > {1'b0, rx_thr}, 2) |-> prdata[2])
		else $error("receive threshold flag not set");
	chk_txthd_set: assert property (rdf && $past(presetn, 2) && $past(tx_level < {1'b0, tx_thr}, 2) |-> prdata[0])
		else $error("transmit threshold flag not set");
	chk_fault_col: assert property (rdf && $past(presetn, 2) && $past(collision, 2) |-> prdata[8])
		else $error("collision did not set fault");
	chk_hold_on: assert property (controller && (rx_level == FIFO_DEPTH || tx_level == LVL_EMPTY) |=> sclk_hold)
		else $error("controller clock not held");
	chk_hold_off: assert property (!controller |=> !sclk_hold)
		else $error("clock held outside controller mode");
	chk_txthr_rst: assert property ($rose(presetn) |-> tx_thr == 5'h10 && rx_thr == 5'h00)
		else $error("threshold reset value wrong");
endmodule
bind spi_event_flags spi_event_flags_checker spi_event_flags_checker_inst (.pclk, .presetn, .psel, .penable, .pwrite,
	.pready, .rx_pop, .tx_push, .collision, .sclk_hold, .controller, .paddr, .prdata, .rx_level, .tx_level, .tx_thr,
	.rx_thr);

// ### verif/spi_far_peer.sv
// spi_far_peer: behavioural far side of the serial link: select, fault and collision lines.
// assumes: the bench clock paces it; select lines are active low and idle high.
`timescale 1ns/100ps
module spi_far_peer (
	input  wire logic pclk,         // bench clock
	output logic      sel_n,        // select seen by the block
	output logic      psel_in_n,    // peripheral select input
	output logic      char_partial, // character half received
	output logic      collision     // bus collision seen
);
	initial begin
		sel_n = 1'b1;
		psel_in_n = 1'b1;
		char_partial = 1'b0;
		collision = 1'b0;
	end
	// one select frame; with abort set the release comes mid-character
	task automatic frame(input logic abort);
		@(posedge pclk);
		sel_n <= 1'b0;
		char_partial <= abort;
		repeat (3) @(posedge pclk);
		sel_n <= 1'b1;
		@(posedge pclk);
		char_partial <= 1'b0;
	endtask
	// one cycle of either a collision or another controller selecting us
	task automatic hit(input logic col);
		@(posedge pclk);
		collision <= col;
		psel_in_n <= col;
		@(posedge pclk);
		collision <= 1'b0;
		psel_in_n <= 1'b1;
	endtask
endmodule

// ### verif/tb_spi_event_flags.sv
// tb_spi_event_flags: self-checking bench for the event flag block over APB.
// assumes: design and peer model compiled before it; reads are checked from a queue of notes.
`timescale 1ns/100ps
module tb_spi_event_flags;
	import spi_flags_pkg::*;
	typedef struct {logic [31:0] m; logic [31:0] e; logic er;} note_t;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic rx_pop = 1'b0, rx_push = 1'b0, tx_pop = 1'b0, tx_push = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [LVL_W-1:0] rx_level = 6'h00, tx_level = 6'h14;
	logic [NUM_W-1:0] char_count = 16'h0000;
	logic sel_n, psel_in_n, char_partial, collision, pready, pslverr, irq, sclk_hold, controller;
	logic [31:0] prdata;
	logic [THR_W-1:0] rx_thr, tx_thr;
	note_t q[$];
	int err_total = 0, cmp_count = 0, r, t;
	spi_event_flags spi_event_flags_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .rx_level, .tx_level, .rx_pop, .rx_push, .tx_pop, .tx_push, .char_count, .sel_n,
		.psel_in_n, .char_partial, .collision, .irq, .sclk_hold, .controller, .rx_thr, .tx_thr);
	spi_far_peer spi_far_peer_inst (.pclk, .sel_n, .psel_in_n, .char_partial, .collision);
	initial begin
		forever #25 pclk = ~pclk;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ==========================================================
	// apb master
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			err_total++;
			print_verdict();
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input logic er = 1'b0);
		q.push_back('{m, e, er});
		apb(1'b0, a, 32'h0);
	endtask
	// ==========================================================
	// read monitor: oldest note against each completed read
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
			note_t n;
			n = q.pop_front();
			check(prdata & n.m, n.e);
			check({31'h0, pslverr}, {31'h0, n.er});
		end
	end
	// ==========================================================
	// scenarios
	initial begin
		r = $urandom(32'he9acb60e);
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_FLAGS, 32'hFFFFFFFF, 32'h2);
		rd(OFS_DMA, 32'hFFFFFFFF, 32'h10);
		rd(12'h040, 32'hFFFFFFFF, 32'h0, 1'b1);
		apb(1'b1, OFS_FLAGS, 32'hFFFFFFFF);
		rd(OFS_FLAGS, 32'hFFFFFFFF, 32'h0);
		apb(1'b1, OFS_INTEN, 32'h8000);
		rx_pop <= 1'b1;
		@(posedge pclk);
		rx_pop <= 1'b0;
		@(posedge pclk);
		check({31'h0, irq}, 32'h1);
		apb(1'b1, OFS_FLAGS, 32'h0);
		rd(OFS_FLAGS, 32'h8000, 32'h8000);
		apb(1'b1, OFS_INTEN, 32'h0);
		repeat (2) @(posedge pclk);
		check({31'h0, irq}, 32'h0);
		apb(1'b1, OFS_INTEN, 32'h8000);
		rx_pop <= 1'b1;
		apb(1'b1, OFS_FLAGS, 32'h8000);
		rx_pop <= 1'b0;
		rd(OFS_FLAGS, 32'h8000, 32'h8000);
		apb(1'b1, OFS_FLAGS, 32'h8000);
		@(posedge pclk);
		check({31'h0, irq}, 32'h0);
		tx_level <= FIFO_DEPTH;
		tx_push <= 1'b1;
		@(posedge pclk);
		tx_push <= 1'b0;
		rd(OFS_FLAGS, 32'h9000, 32'h1000);
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, OFS_CTRL, 32'(m));
			apb(1'b1, OFS_FLAGS, 32'hFFFF);
			rx_level <= FIFO_DEPTH;
			tx_level <= LVL_EMPTY;
			rx_push <= 1'b1;
			tx_pop <= 1'b1;
			@(posedge pclk);
			rx_push <= 1'b0;
			tx_pop <= 1'b0;
			@(posedge pclk);
			check({31'h0, sclk_hold}, 32'(m));
			check({31'h0, controller}, 32'(m));
			rd(OFS_FLAGS, 32'h600A, m ? 32'h000A : 32'h600A);
			rx_level <= 6'h00;
			tx_level <= 6'h14;
		end
		apb(1'b1, OFS_CTRL, 32'h00030001);
		apb(1'b1, OFS_FLAGS, 32'hFFFF);
		rd(OFS_FLAGS, 32'h0800, 32'h0);
		char_count <= 16'h0003;
		@(posedge pclk);
		rd(OFS_FLAGS, 32'h0800, 32'h0800);
		char_count <= 16'h0000;
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, OFS_CTRL, k == 0 ? 32'h3 : 32'(k == 1));
			apb(1'b1, OFS_FLAGS, 32'hFFFF);
			spi_far_peer_inst.hit(k == 2);
			rd(OFS_FLAGS, 32'h0100, k == 1 ? 32'h0 : 32'h0100);
		end
		for (int a = 1; a >= 0; a--) begin
			apb(1'b1, OFS_FLAGS, 32'hFFFF);
			spi_far_peer_inst.frame(a[0]);
			rd(OFS_FLAGS, 32'h0230, a ? 32'h0230 : 32'h0030);
		end
		repeat (6) begin
			r = $urandom % 31;
			t = $urandom % 31;
			apb(1'b1, OFS_DMA, 32'((r << 16) | t));
			rd(OFS_DMA, 32'hFFFFFFFF, 32'((r << 16) | t));
			check({27'h0, rx_thr}, 32'(r));
			check({27'h0, tx_thr}, 32'(t));
			rx_level <= 6'($urandom % 33);
			tx_level <= 6'(1 + $urandom % 31);
			apb(1'b1, OFS_FLAGS, 32'h5);
			rd(OFS_FLAGS, 32'h5, {29'h0, rx_level > r, 1'b0, tx_level < t});
		end
		repeat (2) @(posedge pclk);
		print_verdict();
	end
endmodule
